// ===== hw/fbc_defines.svh
// constants of the flash byte-mode command controller
`ifndef FBC_DEFINES_SVH
`define FBC_DEFINES_SVH

// ************************************************
// timing
// ************************************************
`define FBC_CLK_NS 50
`define FBC_T_SETUP_NS 30
`define FBC_T_WP_NS 35
`define FBC_T_ACC_NS 70
`define FBC_T_HOLD_NS 20
`define FBC_CYC_MIN(ns) (((ns) + `FBC_CLK_NS - 1) / `FBC_CLK_NS)

// ************************************************
// command addresses and data
// ************************************************
`define FBC_A_UNLK1 21'h000aaa
`define FBC_A_UNLK2 21'h000555
`define FBC_A_CFI 21'h000055
`define FBC_BANK_LO 12'haaa
`define FBC_D_AA 8'haa
`define FBC_D_55 8'h55
`define FBC_D_PROG 8'ha0
`define FBC_D_ASEL 8'h90
`define FBC_D_SECT 8'h88
`define FBC_D_BYP 8'h20
`define FBC_D_ERASE 8'h80
`define FBC_D_CHIP 8'h10
`define FBC_D_SERASE 8'h30
`define FBC_D_SUSP 8'hb0
`define FBC_D_RESUME 8'h30
`define FBC_D_RESET 8'hf0
`define FBC_D_CFI 8'h98
`define FBC_D_ZERO 8'h00

// ************************************************
// register map and fields
// ************************************************
`define FBC_REG_CTRL 5'h00
`define FBC_REG_ADDR 5'h04
`define FBC_REG_WDATA 5'h08
`define FBC_REG_STATUS 5'h0c
`define FBC_REG_RDATA 5'h10
`define FBC_CTRL_GO 8
`define FBC_ST_BUSY 0
`define FBC_ST_ERR 1
`define FBC_ST_BYP 2
`define FBC_ST_SUSP 3
`define FBC_ST_SERA 4
`define FBC_ST_RB 5
`define FBC_ST_PFAIL 6
`define FBC_ST_ASEL 7

`endif

// ===== hw/fbc_pkg.sv
// types of the flash byte-mode command controller
package fbc_pkg;
   typedef enum logic [3:0] {
      OP_READ = 4'h0, OP_RESET = 4'h1, OP_AUTOSEL = 4'h2,
      OP_SEC_ENTER = 4'h3, OP_SEC_EXIT = 4'h4, OP_PROGRAM = 4'h5,
      OP_BYP_ENTER = 4'h6, OP_BYP_PROG = 4'h7, OP_BYP_EXIT = 4'h8,
      OP_CHIP_ERASE = 4'h9, OP_SECT_ERASE = 4'ha, OP_SUSPEND = 4'hb,
      OP_RESUME = 4'hc, OP_CFI = 4'hd
   } fbc_op_t;
   typedef enum logic [2:0] {
      AS_UNLK1 = 3'h0, AS_UNLK2 = 3'h1, AS_BANK = 3'h2,
      AS_USER = 3'h3, AS_CFI = 3'h4
   } fbc_asel_t;
   typedef enum logic [4:0] {
      H_IDLE = 5'b00001, H_ISSUE = 5'b00010, H_WAIT = 5'b00100,
      H_POLL = 5'b01000, H_PWAIT = 5'b10000
   } fbc_hst_t;
   typedef enum logic [3:0] {
      CY_IDLE = 4'b0001, CY_SETUP = 4'b0010, CY_STROBE = 4'b0100,
      CY_HOLD = 4'b1000
   } fbc_cst_t;
endpackage

// ===== hw/fbc_cycle.sv
// one read or write cycle on the flash pins
`timescale 1ns/1ns
`include "fbc_defines.svh"
module fbc_cycle import fbc_pkg::*; (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // cycle request
   input wire logic cyc_start,
   input wire logic cyc_rd,
   input wire logic [20:0] cyc_addr,
   input wire logic [7:0] cyc_wdata,
   output logic cyc_done,
   output logic [7:0] cyc_rdata,
   // flash pins
   output logic [20:0] flash_addr,
   output logic [7:0] flash_dq_out,
   input wire logic [7:0] flash_dq_in,
   output logic flash_dq_oe_n,
   output logic flash_ce_n,
   output logic flash_we_n,
   output logic flash_oe_n
);
   localparam logic [3:0] SETUP_C = 4'(`FBC_CYC_MIN(`FBC_T_SETUP_NS));
   localparam logic [3:0] WP_C = 4'(`FBC_CYC_MIN(`FBC_T_WP_NS));
   localparam logic [3:0] ACC_C = 4'(`FBC_CYC_MIN(`FBC_T_ACC_NS));
   localparam logic [3:0] HOLD_C = 4'(`FBC_CYC_MIN(`FBC_T_HOLD_NS));

   fbc_cst_t st_r;
   logic [3:0] cnt_r;
   logic rd_r;

   assign cyc_done = (st_r == CY_HOLD) && (cnt_r == 4'h0);

   // ************************************************
   // phase sequencing
   // ************************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_r <= CY_IDLE;
         cnt_r <= 4'h0;
      end else begin
         unique case (st_r)
            CY_IDLE: if (cyc_start) begin
               st_r <= CY_SETUP;
               cnt_r <= SETUP_C - 4'h1;
            end
            CY_SETUP: if (cnt_r == 4'h0) begin
               st_r <= CY_STROBE;
               cnt_r <= (rd_r ? ACC_C : WP_C) - 4'h1;
            end else cnt_r <= cnt_r - 4'h1;
            CY_STROBE: if (cnt_r == 4'h0) begin
               st_r <= CY_HOLD;
               cnt_r <= HOLD_C - 4'h1;
            end else cnt_r <= cnt_r - 4'h1;
            CY_HOLD: if (cnt_r == 4'h0) begin
               st_r <= CY_IDLE;
            end else cnt_r <= cnt_r - 4'h1;
         endcase
      end
   end

   // ************************************************
   // pin drive
   // ************************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         flash_addr <= 21'h0;
         flash_dq_out <= 8'h0;
         flash_dq_oe_n <= 1'b1;
         flash_ce_n <= 1'b1;
         flash_we_n <= 1'b1;
         flash_oe_n <= 1'b1;
         cyc_rdata <= 8'h0;
         rd_r <= 1'b0;
      end else begin
         unique case (st_r)
            CY_IDLE: if (cyc_start) begin
               flash_addr <= cyc_addr;
               flash_dq_out <= cyc_wdata;
               flash_dq_oe_n <= cyc_rd;
               flash_ce_n <= 1'b0;
               rd_r <= cyc_rd;
            end
            CY_SETUP: if (cnt_r == 4'h0) begin
               flash_we_n <= rd_r;
               flash_oe_n <= !rd_r;
            end
            CY_STROBE: if (cnt_r == 4'h0) begin
               flash_we_n <= 1'b1;
               flash_oe_n <= 1'b1;
               if (rd_r) cyc_rdata <= flash_dq_in;
            end
            CY_HOLD: if (cnt_r == 4'h0) begin
               flash_ce_n <= 1'b1;
               flash_dq_oe_n <= 1'b1;
            end
         endcase
      end
   end

   // ************************************************
   // checks
   // ************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   AST_WE_OE_EXCL: assert property (!(!flash_we_n && !flash_oe_n))
      else $error("write and output strobes low together");
   AST_WE_WIDTH: assert property ($fell(flash_we_n) |=> flash_we_n)
      else $error("write strobe width wrong");
   AST_WE_FRAME: assert property (!flash_we_n |-> !flash_ce_n
      && !flash_dq_oe_n && $stable(flash_addr)
      && $stable(flash_dq_out))
      else $error("address or data moved under write strobe");
endmodule

// ===== hw/fbc_host.sv
// host controller issuing byte-mode flash command sequences
//
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns
`include "fbc_defines.svh"
// What this block does
// - plain array read is one read cycle, no unlock writes first
// - reset writes f0 once; used to leave autoselect or after timeout
// - all command cycles are writes except read and autoselect fourth
// - program: aa@aaa, 55@555, a0@aaa, then value at location
// - autoselect: unlock, 90 at bank plus aaa, then read at location
// - secured sector entry: unlock pair then 88 at aaa
// - secured sector exit: unlock pair, 90 at aaa, 00 anywhere
// - bypass entry: unlock pair then 20 at aaa
// - bypass program: a0 anywhere, then value at location
// - bypass exit: 90 then 00, any addresses
// - erase: unlock, 80, unlock, then 10 at aaa or 30 at sector
// - suspend: b0 at location, only while a sector erase runs
// - resume: 30 at location, only while suspended
module fbc_host import fbc_pkg::*; (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // avalon slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // flash pins
   output logic [20:0] flash_addr,
   output logic [7:0] flash_dq_out,
   input wire logic [7:0] flash_dq_in,
   output logic flash_dq_oe_n,
   output logic flash_ce_n,
   output logic flash_we_n,
   output logic flash_oe_n,
   input wire logic ready_busy_out
);
   // ************************************************
   // functions
   // ************************************************
   // step word: {last, rd, user data, asel, data}
   function automatic logic [13:0] fbc_step(fbc_op_t op,
                                            logic [2:0] idx);
      logic [13:0] s;
      s = {1'b1, 1'b0, 1'b0, AS_USER, `FBC_D_RESET};
      unique case (op)
         OP_READ: s = {1'b1, 1'b1, 1'b0, AS_USER, `FBC_D_ZERO};
         OP_RESET: s = {1'b1, 1'b0, 1'b0, AS_USER, `FBC_D_RESET};
         OP_SUSPEND: s = {1'b1, 1'b0, 1'b0, AS_USER, `FBC_D_SUSP};
         OP_RESUME: s = {1'b1, 1'b0, 1'b0, AS_USER, `FBC_D_RESUME};
         OP_CFI: s = {1'b1, 1'b0, 1'b0, AS_CFI, `FBC_D_CFI};
         OP_BYP_PROG: s = (idx == 3'd0) ?
            {1'b0, 1'b0, 1'b0, AS_USER, `FBC_D_PROG} :
            {1'b1, 1'b0, 1'b1, AS_USER, `FBC_D_ZERO};
         OP_BYP_EXIT: s = (idx == 3'd0) ?
            {1'b0, 1'b0, 1'b0, AS_USER, `FBC_D_ASEL} :
            {1'b1, 1'b0, 1'b0, AS_USER, `FBC_D_ZERO};
         default: begin
            if (idx == 3'd0 || idx == 3'd3 && op[3])
               s = {1'b0, 1'b0, 1'b0, AS_UNLK1, `FBC_D_AA};
            else if (idx == 3'd1 || idx == 3'd4)
               s = {1'b0, 1'b0, 1'b0, AS_UNLK2, `FBC_D_55};
            else if (idx == 3'd5)
               s = (op == OP_CHIP_ERASE) ?
                  {1'b1, 1'b0, 1'b0, AS_UNLK1, `FBC_D_CHIP} :
                  {1'b1, 1'b0, 1'b0, AS_USER, `FBC_D_SERASE};
            else if (op == OP_PROGRAM)
               s = (idx == 3'd2) ?
                  {1'b0, 1'b0, 1'b0, AS_UNLK1, `FBC_D_PROG} :
                  {1'b1, 1'b0, 1'b1, AS_USER, `FBC_D_ZERO};
            else if (op == OP_AUTOSEL)
               s = (idx == 3'd2) ?
                  {1'b0, 1'b0, 1'b0, AS_BANK, `FBC_D_ASEL} :
                  {1'b1, 1'b1, 1'b0, AS_USER, `FBC_D_ZERO};
            else if (op == OP_SEC_ENTER)
               s = {1'b1, 1'b0, 1'b0, AS_UNLK1, `FBC_D_SECT};
            else if (op == OP_SEC_EXIT)
               s = (idx == 3'd2) ?
                  {1'b0, 1'b0, 1'b0, AS_UNLK1, `FBC_D_ASEL} :
                  {1'b1, 1'b0, 1'b0, AS_USER, `FBC_D_ZERO};
            else if (op == OP_BYP_ENTER)
               s = {1'b1, 1'b0, 1'b0, AS_UNLK1, `FBC_D_BYP};
            else
               s = {1'b0, 1'b0, 1'b0, AS_UNLK1, `FBC_D_ERASE};
         end
      endcase
      return s;
   endfunction

   function automatic logic [20:0] fbc_addr(fbc_asel_t a,
                                            logic [20:0] loc);
      unique case (a)
         AS_UNLK1: return `FBC_A_UNLK1;
         AS_UNLK2: return `FBC_A_UNLK2;
         AS_BANK: return {loc[20:12], `FBC_BANK_LO};
         AS_CFI: return `FBC_A_CFI;
         default: return loc;
      endcase
   endfunction

   function automatic logic fbc_allowed(logic [3:0] op, logic byp,
      logic susp, logic asl, logic sera, logic rb);
      unique case (op)
         OP_READ, OP_RESET: return 1'b1;
         OP_BYP_PROG, OP_BYP_EXIT: return byp;
         OP_SUSPEND: return sera && !rb && !susp && !byp;
         OP_RESUME: return susp;
         OP_CFI: return (rb || asl) && !byp;
         OP_AUTOSEL: return !byp;
         OP_PROGRAM: return !byp && !asl;
         OP_SEC_ENTER, OP_SEC_EXIT, OP_BYP_ENTER, OP_CHIP_ERASE,
         OP_SECT_ERASE: return !byp && !asl && !susp;
         default: return 1'b0;
      endcase
   endfunction

   // ************************************************
   // declarations
   // ************************************************
   fbc_hst_t st_r;
   fbc_op_t op_r;
   logic [2:0] idx_r;
   logic [20:0] loc_r;
   logic [7:0] val_r, rd_byte_r;
   logic [3:0] ctrl_op_r;
   logic byp_r, susp_r, asl_r, sera_r, err_r, pfail_r, tmo_r, ack_r;
   logic [13:0] step;
   logic cyc_start, cyc_done, cyc_rd, busy, wr_ok, go, accept, last;
   logic [7:0] cyc_rdata, cyc_wdata;
   logic [20:0] cyc_addr;
   logic [31:0] stat;

   assign step = fbc_step(op_r, idx_r);
   assign last = step[13];
   assign busy = (st_r != H_IDLE);
   assign cyc_start = (st_r == H_ISSUE) || (st_r == H_POLL);
   assign cyc_rd = (st_r == H_POLL) || step[12];
   assign cyc_addr = (st_r == H_POLL) ? loc_r
                   : fbc_addr(fbc_asel_t'(step[10:8]), loc_r);
   assign cyc_wdata = step[11] ? val_r : step[7:0];
   assign wr_ok = avs_write && ack_r;
   assign go = wr_ok && (avs_address == `FBC_REG_CTRL)
               && avs_byteenable[1] && avs_writedata[`FBC_CTRL_GO];
   assign accept = go && !busy && fbc_allowed(avs_writedata[3:0],
                   byp_r, susp_r, asl_r, sera_r, ready_busy_out);

   // ************************************************
   // avalon slave, one wait state
   // ************************************************
   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

   always_comb begin
      stat = 32'h0;
      stat[`FBC_ST_BUSY] = busy;
      stat[`FBC_ST_ERR] = err_r;
      stat[`FBC_ST_BYP] = byp_r;
      stat[`FBC_ST_SUSP] = susp_r;
      stat[`FBC_ST_SERA] = sera_r;
      stat[`FBC_ST_RB] = ready_busy_out;
      stat[`FBC_ST_PFAIL] = pfail_r;
      stat[`FBC_ST_ASEL] = asl_r;
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ack_r <= 1'b0;
         avs_readdata <= 32'h0;
      end else begin
         ack_r <= (avs_read || avs_write) && !ack_r;
         if (avs_read && !ack_r) begin
            unique case (avs_address)
               `FBC_REG_CTRL: avs_readdata <= {28'h0, ctrl_op_r};
               `FBC_REG_ADDR: avs_readdata <= {11'h0, loc_r};
               `FBC_REG_WDATA: avs_readdata <= {24'h0, val_r};
               `FBC_REG_STATUS: avs_readdata <= stat;
               `FBC_REG_RDATA: avs_readdata <= {24'h0, rd_byte_r};
               default: avs_readdata <= 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctrl_op_r <= 4'h0;
         loc_r <= 21'h0;
         val_r <= 8'h0;
      end else if (wr_ok && !busy) begin
         if (avs_address == `FBC_REG_CTRL && avs_byteenable[0])
            ctrl_op_r <= avs_writedata[3:0];
         if (avs_address == `FBC_REG_ADDR) begin
            if (avs_byteenable[0]) loc_r[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1]) loc_r[15:8] <= avs_writedata[15:8];
            if (avs_byteenable[2])
               loc_r[20:16] <= avs_writedata[20:16];
         end
         if (avs_address == `FBC_REG_WDATA && avs_byteenable[0])
            val_r <= avs_writedata[7:0];
      end
   end

   // ************************************************
   // sequencer
   // ************************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_r <= H_IDLE;
         op_r <= OP_READ;
         idx_r <= 3'h0;
         tmo_r <= 1'b0;
      end else begin
         unique case (st_r)
            H_IDLE: if (accept) begin
               op_r <= fbc_op_t'(avs_writedata[3:0]);
               idx_r <= 3'h0;
               tmo_r <= 1'b0;
               st_r <= H_ISSUE;
            end
            H_ISSUE: st_r <= H_WAIT;
            H_WAIT: if (cyc_done) begin
               if (!last) begin
                  idx_r <= idx_r + 3'h1;
                  st_r <= H_ISSUE;
               end else if (op_r == OP_PROGRAM || op_r == OP_BYP_PROG)
                  st_r <= H_POLL;
               else
                  st_r <= H_IDLE;
            end
            H_POLL: st_r <= H_PWAIT;
            H_PWAIT: if (cyc_done) begin
               if (cyc_rdata[7] == val_r[7]) begin
                  st_r <= H_IDLE;
               end else if (cyc_rdata[5] && tmo_r) begin
                  op_r <= OP_RESET;
                  idx_r <= 3'h0;
                  st_r <= H_ISSUE;
               end else begin
                  tmo_r <= cyc_rdata[5];
                  st_r <= H_POLL;
               end
            end
         endcase
      end
   end

   // ************************************************
   // mode tracking and flags
   // ************************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         byp_r <= 1'b0;
         susp_r <= 1'b0;
         asl_r <= 1'b0;
         sera_r <= 1'b0;
      end else if (st_r == H_WAIT && cyc_done && last) begin
         unique case (op_r)
            OP_BYP_ENTER: byp_r <= 1'b1;
            OP_BYP_EXIT: byp_r <= 1'b0;
            OP_AUTOSEL: asl_r <= 1'b1;
            OP_RESET: asl_r <= 1'b0;
            OP_SECT_ERASE: sera_r <= 1'b1;
            OP_SUSPEND: susp_r <= 1'b1;
            OP_RESUME: susp_r <= 1'b0;
            default: ;
         endcase
      end else if (sera_r && ready_busy_out && !susp_r && !busy)
         sera_r <= 1'b0;
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         err_r <= 1'b0;
         pfail_r <= 1'b0;
         rd_byte_r <= 8'h0;
      end else begin
         if (go && !accept)
            err_r <= 1'b1;
         else if (wr_ok && avs_address == `FBC_REG_STATUS
                  && avs_byteenable[0] && avs_writedata[`FBC_ST_ERR])
            err_r <= 1'b0;
         if (st_r == H_PWAIT && cyc_done && cyc_rdata[5] && tmo_r
             && cyc_rdata[7] != val_r[7])
            pfail_r <= 1'b1;
         else if (wr_ok && avs_address == `FBC_REG_STATUS
                  && avs_byteenable[0] && avs_writedata[`FBC_ST_PFAIL])
            pfail_r <= 1'b0;
         if (cyc_done && (st_r == H_PWAIT || step[12]))
            rd_byte_r <= cyc_rdata;
      end
   end

   fbc_cycle u_cycle (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .cyc_start(cyc_start),
      .cyc_rd(cyc_rd),
      .cyc_addr(cyc_addr),
      .cyc_wdata(cyc_wdata),
      .cyc_done(cyc_done),
      .cyc_rdata(cyc_rdata),
      .flash_addr(flash_addr),
      .flash_dq_out(flash_dq_out),
      .flash_dq_in(flash_dq_in),
      .flash_dq_oe_n(flash_dq_oe_n),
      .flash_ce_n(flash_ce_n),
      .flash_we_n(flash_we_n),
      .flash_oe_n(flash_oe_n)
   );

   // ************************************************
   // checks
   // ************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence s_unlock1;
      cyc_start && !cyc_rd && cyc_addr == `FBC_A_UNLK1
      && cyc_wdata == `FBC_D_AA;
   endsequence
   sequence s_unlock2;
      cyc_start && !cyc_rd && cyc_addr == `FBC_A_UNLK2
      && cyc_wdata == `FBC_D_55;
   endsequence

   AST_PROG_UNLOCK: assert property (accept
      && avs_writedata[3:0] == OP_PROGRAM |=> s_unlock1
      ##[2:40] s_unlock2)
      else $error("program sequence does not open with unlock");
   AST_PROG_CMD: assert property (cyc_start && op_r == OP_PROGRAM
      && idx_r == 3'd2 |-> cyc_wdata == `FBC_D_PROG
      && cyc_addr == `FBC_A_UNLK1)
      else $error("program command byte wrong");
   AST_RESET_F0: assert property (cyc_start && op_r == OP_RESET
      |-> cyc_wdata == `FBC_D_RESET && !cyc_rd && last)
      else $error("reset is not a single f0 write");
   AST_ASEL_READ: assert property (cyc_start && op_r == OP_AUTOSEL
      && idx_r == 3'd3 |-> cyc_rd && cyc_addr == loc_r)
      else $error("autoselect fourth cycle not a read");
   AST_READ_ONE: assert property (accept
      && avs_writedata[3:0] == OP_READ |=> cyc_start && cyc_rd
      ##1 (st_r == H_WAIT) [*3])
      else $error("array read not a single read cycle");
   AST_RESUME_GATE: assert property (cyc_start
      && op_r == OP_RESUME |-> susp_r)
      else $error("resume issued while not suspended");
   AST_SERASE_LAST: assert property (cyc_start
      && op_r == OP_SECT_ERASE && idx_r == 3'd5
      |-> cyc_wdata == `FBC_D_SERASE && cyc_addr == loc_r)
      else $error("sector erase final cycle wrong");
   AST_POLL_DONE: assert property (st_r == H_PWAIT && cyc_done
      && cyc_rdata[7] == val_r[7] |=> st_r == H_IDLE
      && rd_byte_r == $past(cyc_rdata))
      else $error("polling does not finish on matching bit");
endmodule

// ===== dv/fbc_flash_model.sv
// behavioural byte-mode flash device on the far side of the controller
`timescale 1ns/1ns
module fbc_flash_model #(
   parameter logic [7:0] MAKER_CODE = 8'ha7, // arbitrary value
   parameter logic [7:0] PART_CODE = 8'h3d // arbitrary value
) (
   // clock for busy timing
   input wire logic clk_sys,
   // flash pins
   input wire logic [20:0] flash_addr,
   input wire logic [7:0] flash_dq_out,
   output logic [7:0] flash_dq_in,
   input wire logic flash_ce_n,
   input wire logic flash_we_n,
   input wire logic flash_oe_n,
   output logic ready_busy_out
);
   logic [7:0] mem [16];
   logic [7:0] rd;
   logic [7:0] last = 8'h00;
   logic [7:0] d;
   logic [20:0] la = 21'h0;
   logic [2:0] st = 3'h0;
   logic asel = 1'b0;
   logic byp = 1'b0;
   logic sus = 1'b0;
   time t_done = 0;
   initial ready_busy_out = 1'b1;
   always @(negedge (flash_we_n | flash_ce_n)) la = flash_addr;
   always @(posedge (flash_we_n | flash_ce_n)) begin
      d = flash_dq_out;
      if (d == 8'hf0) begin
         asel = 1'b0;
         st = 3'h0;
      end else if (d == 8'hb0 && !ready_busy_out) begin
         sus = 1'b1;
         t_done = $time;
      end else if (d == 8'h30 && sus) begin
         sus = 1'b0;
         t_done = $time + 4000;
      end else if (st == 3'h3) begin
         mem[la[3:0]] = d;
         t_done = $time + 1000;
         st = 3'h0;
      end else if (byp) begin
         if (st == 3'h4 && d == 8'h00) byp = 1'b0;
         st = d == 8'ha0 ? 3'h3 : d == 8'h90 ? 3'h4 : 3'h0;
      end else if (st == 3'h0 && la[11:0] == 12'haaa && d == 8'haa) begin
         st = 3'h1;
      end else if (st == 3'h1 && la[11:0] == 12'h555 && d == 8'h55) begin
         st = 3'h2;
      end else begin
         if (st == 3'h2 && la[11:0] == 12'haaa) begin
            asel = asel | (d == 8'h90);
            byp = d == 8'h20;
         end
         if (st == 3'h2 && d == 8'h30) t_done = $time + 4000;
         st = (st == 3'h2 && la[11:0] == 12'haaa && d == 8'ha0) ?
            3'h3 : 3'h0;
      end
   end
   always @* begin
      if (!asel) rd = mem[flash_addr[3:0]];
      else if (flash_addr[7:0] == 8'h00) rd = MAKER_CODE;
      else if (flash_addr[7:0] == 8'h02) rd = PART_CODE;
      else if (flash_addr[7:0] == 8'h06) rd = 8'h00;
      else rd = 8'h01;
      if (!ready_busy_out) rd[7] = ~rd[7];
   end
   always @(posedge flash_oe_n) last = rd;
   assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? rd : ~last;
   always @(posedge clk_sys) ready_busy_out <= $time >= t_done;
endmodule

// ===== dv/fbc_host_test.sv
// self-checking bench of the flash command controller
`timescale 1ns/1ns
`include "fbc_defines.svh"
module fbc_host_test import fbc_pkg::*; ;
   typedef struct packed {
      logic [3:0] op; logic [20:0] a; logic [7:0] wd, ex; bit ck; logic er;
   } fbc_row_t;
   localparam logic [7:0] MK = 8'ha7; // arbitrary value
   localparam logic [7:0] PT = 8'h3d; // arbitrary value
   localparam logic N = 1'b0;
   localparam logic Y = 1'b1;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest, flash_dq_oe_n, flash_ce_n, flash_we_n, flash_oe_n;
   logic ready_busy_out;
   logic [20:0] flash_addr;
   logic [7:0] flash_dq_out, flash_dq_in;
   int bad_count = 0;
   int comparisons = 0;
   fbc_row_t rows [26] = '{
      '{4'h5,21'h3,8'h5a,8'h0,N,N}, '{4'h0,21'h3,8'h0,8'h5a,Y,N},
      '{4'h2,21'h0,8'h0,MK,Y,N}, '{4'h1,21'h0,8'h0,8'h0,N,N},
      '{4'h2,21'h2,8'h0,PT,Y,N}, '{4'h1,21'h0,8'h0,8'h0,N,N},
      '{4'h2,21'h6,8'h0,8'h00,Y,N}, '{4'h1,21'h0,8'h0,8'h0,N,N},
      '{4'h2,21'h1004,8'h0,8'h01,Y,N}, '{4'h1,21'h0,8'h0,8'h0,N,N},
      '{4'h0,21'h3,8'h0,8'h5a,Y,N}, '{4'h7,21'h4,8'h4c,8'h0,N,Y},
      '{4'h6,21'h0,8'h0,8'h0,N,N}, '{4'h7,21'h4,8'h4c,8'h0,N,N},
      '{4'h8,21'h0,8'h0,8'h0,N,N}, '{4'h0,21'h4,8'h0,8'h4c,Y,N},
      '{4'h3,21'h0,8'h0,8'h0,N,N}, '{4'h4,21'h0,8'h0,8'h0,N,N},
      '{4'h1,21'h0,8'h0,8'h0,N,N}, '{4'hd,21'h0,8'h0,8'h0,N,N},
      '{4'h9,21'h0,8'h0,8'h0,N,N}, '{4'hc,21'h0,8'h0,8'h0,N,Y},
      '{4'ha,21'h2000,8'h0,8'h0,N,N}, '{4'hb,21'h2000,8'h0,8'h0,N,N},
      '{4'h0,21'h4,8'h0,8'h4c,Y,N}, '{4'hc,21'h2000,8'h0,8'h0,N,N}};
   always #25 clk_sys = ~clk_sys;
   fbc_host fbc_host_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
      .flash_dq_in(flash_dq_in), .flash_dq_oe_n(flash_dq_oe_n),
      .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
      .flash_oe_n(flash_oe_n), .ready_busy_out(ready_busy_out));
   fbc_flash_model #(.MAKER_CODE(MK), .PART_CODE(PT)) fbc_flash_model_i (
      .clk_sys(clk_sys), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
      .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n),
      .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
      .ready_busy_out(ready_busy_out));
   task automatic report_and_stop;
      $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic idle;
      do begin
         av(1'b0, `FBC_REG_STATUS, 32'h0);
      end while (q[`FBC_ST_BUSY] !== 1'b0);
   endtask
   initial begin
      #2000000;
      bad_count++;
      report_and_stop;
   end
   initial begin
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      foreach (rows[i]) begin
         av(1'b1, `FBC_REG_STATUS, 32'h42);
         av(1'b1, `FBC_REG_ADDR, {11'h0, rows[i].a});
         av(1'b1, `FBC_REG_WDATA, {24'h0, rows[i].wd});
         av(1'b1, `FBC_REG_CTRL, {23'h0, 1'b1, 4'h0, rows[i].op});
         idle;
         cmp({31'h0, q[`FBC_ST_ERR]}, {31'h0, rows[i].er});
         if (rows[i].ck) begin
            av(1'b0, `FBC_REG_RDATA, 32'h0);
            cmp({24'h0, q[7:0]}, {24'h0, rows[i].ex});
         end
      end
      av(1'b1, `FBC_REG_CTRL, 32'h105);
      av(1'b1, `FBC_REG_CTRL, 32'h100);
      av(1'b0, `FBC_REG_STATUS, 32'h0);
      cmp({31'h0, q[`FBC_ST_BUSY]}, 32'h1);
      idle;
      cmp({31'h0, q[`FBC_ST_ERR]}, 32'h1);
      cmp({31'h0, q[`FBC_ST_RB]}, 32'h1);
      av(1'b0, 5'h14, 32'h0);
      cmp(q, 32'h0);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      cmp({28'h0, flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe_n},
         32'hf);
      cmp(avs_readdata, 32'h0);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      av(1'b0, `FBC_REG_STATUS, 32'h0);
      cmp(q, 32'h20);
      report_and_stop;
   end
endmodule
